// File: pkg/hcp_consts.vh
`ifndef HCP_CONSTS_VH
`define HCP_CONSTS_VH

// register space of the host port
`define HCP_ADDR_W 11
`define HCP_DATA_W 8
`define HCP_MEM_DEPTH 2048

// input synchroniser word: field positions
`define HCP_SY_W 26
`define HCP_SY_CS 25
`define HCP_SY_ALE 24
`define HCP_SY_STB 23
`define HCP_SY_DIR 22
`define HCP_SY_PS 21
`define HCP_SY_STYLE 20
`define HCP_SY_MUX 19
`define HCP_SY_A_HI 18
`define HCP_SY_A_LO 8
`define HCP_SY_D_HI 7
`define HCP_SY_D_LO 0
// synchroniser reset: chip select, latch strobe, strobe and direction high, serial strap
`define HCP_SY_RST 26'h3C00000

// serial frame: direction bit, 11 address bits, 8 data bits
`define HCP_SER_CNT_W 5
`define HCP_SER_ADDR_END 5'h0C
`define HCP_SER_FRAME_END 5'h14

// cycles from read start until register data is on the bus
`define HCP_RD_WAIT 2'h2

// reset values
`define HCP_ADDR_RST 11'h000
`define HCP_DATA_RST 8'h00

`endif

// File: core/hcp_regmem.v
// register array behind the host port, one byte per address
module hcp_regmem (
    // clock
    input wire mclk,
    input wire rst_n,
    // access port
    input wire we,
    input wire re,
    input wire [10:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);

    reg [7:0] mem [0:2047];

    // array itself has no reset; contents belong to the rest of the device
    always @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // registered read data
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (re) begin
            rdata <= mem[addr];
        end
    end

endmodule // hcp_regmem

// File: core/hcp_port.v
`include "hcp_consts.vh"

module hcp_port (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // straps
    input wire port_type_select,
    input wire bus_style_select,
    input wire bus_multiplex_select,
    // host strobes; data_strobe_n is also shift clock or read strobe,
    // serial_in is also direction select or write strobe
    input wire cs_n,
    input wire address_strobe_n,
    input wire data_strobe_n,
    input wire serial_in,
    // address and data bus
    input wire [10:0] addr,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe,
    // shared serial data / acknowledge / ready output
    output reg serial_out
);

    localparam ST_IDLE = 4'h1;
    localparam ST_READ = 4'h2;
    localparam ST_HOLD = 4'h4;
    localparam ST_DONE = 4'h8;

    // two-stage synchroniser for every pin
    // straps ride it too, so a strap change acts two edges later
    reg [`HCP_SY_W-1:0] sy1;
    reg [`HCP_SY_W-1:0] sy2;
    reg ale_d;
    reg stb_d;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sy1 <= `HCP_SY_RST;
            sy2 <= `HCP_SY_RST;
            ale_d <= 1'b1;
            stb_d <= 1'b1;
        end else begin
            sy1 <= {cs_n, address_strobe_n, data_strobe_n, serial_in, port_type_select,
                bus_style_select, bus_multiplex_select, addr, data_in};
            sy2 <= sy1;
            ale_d <= sy2[`HCP_SY_ALE];
            stb_d <= sy2[`HCP_SY_STB];
        end
    end

    // only the second stage is read, never the first
    wire cs_s = sy2[`HCP_SY_CS];
    wire ale_s = sy2[`HCP_SY_ALE];
    wire stb_s = sy2[`HCP_SY_STB];
    wire dir_s = sy2[`HCP_SY_DIR];
    wire [10:0] a_s = sy2[`HCP_SY_A_HI:`HCP_SY_A_LO];
    wire [7:0] d_s = sy2[`HCP_SY_D_HI:`HCP_SY_D_LO];

    // strap decode; levels only, straps are expected to be static
    wire par_mode = sy2[`HCP_SY_PS];
    wire pair_style = sy2[`HCP_SY_STYLE];
    wire mux_bus = sy2[`HCP_SY_MUX];

    // combined 11-bit address from upper pins and shared bus
    function [10:0] mux_addr;
        input [10:0] pins;
        input [7:0] bus;
        begin
            mux_addr = {pins[10:8], bus};
        end
    endfunction

    // memory port, shared by parallel and serial engines
    wire mem_we;
    wire mem_re;
    wire [10:0] mem_addr;
    wire [7:0] mem_wdata;
    wire [7:0] mem_rdata;

    hcp_regmem u_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .we(mem_we),
        .re(mem_re),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // parallel engine

    reg [10:0] lat_addr;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [1:0] wait_cnt;
    reg par_we;
    reg par_re;
    reg [7:0] par_wdata;
    reg [10:0] par_addr;

    // address latch on the falling strobe edge; low address pins ignored
    // a latch strobe in plain or serial mode is ignored
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lat_addr <= `HCP_ADDR_RST;
        end else if (par_mode && mux_bus && ale_d && !ale_s) begin
            lat_addr <= mux_addr(a_s, d_s);
        end
    end

    // strobe decode per style; pair style uses separate read/write strobes
    wire rd_req = pair_style ? !stb_s : (!stb_s && dir_s);
    wire wr_req = pair_style ? !dir_s : (!stb_s && !dir_s);
    wire acc_addr_sel = mux_bus;
    wire [10:0] acc_addr = acc_addr_sel ? lat_addr : a_s;

    // access sequencer; an access begins only while chip select is low
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (par_mode && !cs_s && rd_req) begin
                    next_state = ST_READ;
                end else if (par_mode && !cs_s && wr_req) begin
                    next_state = ST_DONE;
                end
            end
            ST_READ: begin
                // fixed wait so the registered read data settles before the bus turns
                if (wait_cnt == `HCP_RD_WAIT) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // read ends when the strobe or chip select is released
                if (!rd_req || cs_s) begin
                    next_state = ST_IDLE;
                end
            end
            ST_DONE: begin
                // write already taken; one strobe gives exactly one write
                if (!wr_req || cs_s) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            wait_cnt <= 2'h0;
            par_we <= 1'b0;
            par_re <= 1'b0;
            par_wdata <= `HCP_DATA_RST;
            par_addr <= `HCP_ADDR_RST;
        end else begin
            state <= next_state;
            par_we <= 1'b0;
            par_re <= 1'b0;
            if (state == ST_IDLE && next_state == ST_READ) begin
                par_addr <= acc_addr;
                par_re <= 1'b1;
                wait_cnt <= 2'h0;
            end else if (state == ST_READ) begin
                wait_cnt <= wait_cnt + 2'h1;
            end
            // write data taken while the strobe is low
            if (state == ST_IDLE && next_state == ST_DONE) begin
                par_addr <= acc_addr;
                par_wdata <= d_s;
                par_we <= 1'b1;
            end
        end
    end

    // serial engine
    // the shift clock is only sampled, so each of its phases must last three mclk or more

    wire ser_act = !par_mode && !cs_s;
    wire sclk_rise = ser_act && !stb_d && stb_s;
    wire sclk_fall = ser_act && stb_d && !stb_s;

    reg [4:0] bit_cnt;
    reg ser_rd;
    reg [10:0] ser_addr;
    reg [7:0] ser_sh;
    reg ser_re;
    reg ser_we;
    reg ser_load;
    reg [7:0] out_sh;
    reg ser_bit;

    // input shifting on rising shift clock edges
    // the count stops at the frame end, so surplus shift clocks are ignored
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 5'h00;
            ser_rd <= 1'b0;
            ser_addr <= `HCP_ADDR_RST;
            ser_sh <= `HCP_DATA_RST;
            ser_re <= 1'b0;
            ser_we <= 1'b0;
        end else begin
            ser_re <= 1'b0;
            ser_we <= 1'b0;
            if (!ser_act) begin
                bit_cnt <= 5'h00; // chip select high ends the frame
            end else if (sclk_rise && bit_cnt != `HCP_SER_FRAME_END) begin
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == 5'h00) begin
                    ser_rd <= dir_s;
                end else if (bit_cnt < `HCP_SER_ADDR_END) begin
                    ser_addr <= {ser_addr[9:0], dir_s};
                end else begin
                    ser_sh <= {ser_sh[6:0], dir_s};
                end
                if (bit_cnt == `HCP_SER_ADDR_END - 5'h01 && ser_rd) begin
                    ser_re <= 1'b1;
                end
                if (bit_cnt == `HCP_SER_FRAME_END - 5'h01 && !ser_rd) begin
                    ser_we <= 1'b1;
                end
            end
        end
    end

    // output shifting on falling edges; first data bit follows the last address bit
    // ser_load waits for the registered read data of the frame's address
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ser_load <= 1'b0;
            out_sh <= `HCP_DATA_RST;
            ser_bit <= 1'b0;
        end else if (!ser_act) begin
            ser_load <= 1'b0;
        end else begin
            if (ser_re) begin
                ser_load <= 1'b1;
            end
            if (sclk_fall && ser_load) begin
                ser_load <= 1'b0;
                ser_bit <= mem_rdata[7];
                out_sh <= {mem_rdata[6:0], 1'b0};
            end else if (sclk_fall && ser_rd && bit_cnt > `HCP_SER_ADDR_END) begin
                ser_bit <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    // memory port and pins
    // the port-type strap picks the engine; the other one stays quiet

    assign mem_we = par_mode ? par_we : ser_we;
    assign mem_re = par_mode ? par_re : ser_re;
    assign mem_addr = par_mode ? par_addr : ser_addr;
    assign mem_wdata = par_mode ? par_wdata : ser_sh;

    // pin drivers all registered; the bus is driven only during a read
    // serial_out resets high: no acknowledge, ready, and an idle serial line
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= `HCP_DATA_RST;
            data_oe <= 1'b0;
            serial_out <= 1'b1;
        end else begin
            data_out <= mem_rdata;
            data_oe <= par_mode && (next_state == ST_HOLD);
            if (!par_mode) begin
                serial_out <= ser_bit;
            end else if (pair_style) begin
                // ready low only while the read data is still being fetched
                serial_out <= !(next_state == ST_READ);
            end else begin
                // acknowledge low once data is on the bus or a write was taken
                serial_out <= !(next_state == ST_HOLD || next_state == ST_DONE);
            end
        end
    end

endmodule // hcp_port

// File: test/hcp_port_monitor.sv
module hcp_port_monitor (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // straps and strobes
    input wire port_type_select,
    input wire bus_style_select,
    input wire bus_multiplex_select,
    input wire cs_n,
    input wire address_strobe_n,
    input wire data_strobe_n,
    input wire serial_in,
    // bus and answer
    input wire [10:0] addr,
    input wire [7:0] data_in,
    input wire [7:0] data_out,
    input wire data_oe,
    input wire serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // the bus is only driven for a read strobe seen through the synchroniser
    property p_oe_rd;
        $rose(data_oe) |-> port_type_select && !$past(cs_n, 4) && !$past(data_strobe_n, 4)
            && $past(serial_in, 4);
    endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("bus driven without read");
    property p_oe_hold;
        $fell(data_oe) |-> $past(cs_n, 2) || $past(data_strobe_n, 2);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("bus dropped mid read");
    property p_oe_ser;
        !port_type_select && !$past(port_type_select, 4) |-> !data_oe;
    endproperty
    a_oe_ser: assert property (p_oe_ser) else $error("bus driven in serial mode");
    // acknowledge and ready line up with the read data; acknowledge also answers a write
    property p_ack_rd;
        $rose(data_oe) && !bus_style_select |-> !serial_out;
    endproperty
    a_ack_rd: assert property (p_ack_rd) else $error("no ack with data");
    property p_ack_wr;
        port_type_select && !bus_style_select && !cs_n && !serial_in && $fell(data_strobe_n)
            |-> ##[1:10] !serial_out;
    endproperty
    a_ack_wr: assert property (p_ack_wr) else $error("no ack for write");
    property p_rdy_up;
        $rose(data_oe) && bus_style_select |-> serial_out;
    endproperty
    a_rdy_up: assert property (p_rdy_up) else $error("ready low with data");
    property p_rdy_wait;
        port_type_select && bus_style_select && serial_in && !cs_n && !data_strobe_n
            && !data_oe && !$past(cs_n, 4) && !$past(data_strobe_n, 4) |-> !serial_out;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready high in wait");
    // frame start and end are excluded; cs_n only clears ser_load there and leaves the output as it is
    property p_so_fall;
        !port_type_select && !$past(port_type_select, 4) && !cs_n && !$past(cs_n, 4)
            && $changed(serial_out) |-> !$past(data_strobe_n, 2);
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("serial out moved late");
    c_rd: cover property ($rose(data_oe));
    c_mux: cover property (bus_multiplex_select && $fell(address_strobe_n));
    c_ser: cover property (!port_type_select && !cs_n && $rose(data_strobe_n));
endmodule // hcp_port_monitor

// File: test/hcp_host_model.sv
module hcp_host_model (
    // clock and straps
    input wire mclk,
    input wire ps,
    input wire style,
    input wire mux,
    // host pins
    output logic cs_n,
    output logic as_n,
    output logic ds_n,
    output logic si,
    output logic [10:0] a,
    output wire [7:0] bus,
    // answer from the port
    input wire [7:0] data_out,
    input wire data_oe,
    input wire so
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] dq = 8'h00;
    // a released parallel host shows the inverse of its last byte, never a stale copy; a serial one shows zero
    assign bus = data_oe ? data_out : dq;
    // idle levels of each mode
    task automatic idle();
        cs_n = 1;
        as_n = ps;
        ds_n = ps;
        si = ps;
        a = 11'h000;
        dq = ps ? ~dq : 8'h00;
    endtask
    // parallel access, held until the answer is sampled on a rising edge
    task automatic par(input bit rd, input logic [10:0] ad, input logic [7:0] d,
                       output logic [7:0] q, output bit ok);
        int n;
        @(negedge mclk);
        cs_n = 0;
        a = mux ? {ad[10:8], ~ad[7:0]} : ad;
        dq = mux ? ad[7:0] : d;
        if (mux) begin
            repeat (4) @(negedge mclk);
            as_n = 0;
            repeat (4) @(negedge mclk);
            as_n = 1;
            dq = d;
        end
        if (rd)
            dq = ~dq;
        repeat (4) @(negedge mclk);
        if (!style) begin
            si = rd;
            @(negedge mclk);
        end
        if (style && !rd)
            si = 0;
        else
            ds_n = 0;
        n = 0;
        ok = 0;
        while (!ok && n < 40) begin
            @(posedge mclk);
            n++;
            ok = style ? (rd ? data_oe === 1'b1 && so === 1'b1 : n > 6) : so === 1'b0;
        end
        q = bus;
        @(negedge mclk);
        idle();
        repeat (8) @(negedge mclk);
    endtask
    // serial frame: direction, address, data; shift clock low outside frames
    task automatic ser(input bit rd, input logic [10:0] ad, input logic [7:0] d,
                       output logic [7:0] q);
        logic [19:0] f;
        f = {rd, ad, d};
        @(negedge mclk);
        cs_n = 0;
        for (int i = 19; i >= 0; i--) begin
            si = f[i];
            repeat (4) @(negedge mclk);
            ds_n = 1;
            repeat (4) @(negedge mclk);
            if (i < 8)
                q[i] = so;
            ds_n = 0;
        end
        repeat (4) @(negedge mclk);
        idle();
        repeat (8) @(negedge mclk);
    endtask
endmodule // hcp_host_model

// File: test/tb_top.sv
bind hcp_port hcp_port_monitor i_mon (.mclk(mclk), .rst_n(rst_n),
    .port_type_select(port_type_select), .bus_style_select(bus_style_select),
    .bus_multiplex_select(bus_multiplex_select), .cs_n(cs_n),
    .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .serial_in(serial_in), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .serial_out(serial_out));

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // {port type, style, multiplex}: ds plain, ds mux, pair plain, pair mux, serial
    localparam logic [2:0] MODES [5] = '{3'b100, 3'b101, 3'b110, 3'b111, 3'b010};
    logic mclk = 0;
    logic rst_n = 0;
    logic ps = 1;
    logic style = 0;
    logic mux = 0;
    wire cs_n, as_n, ds_n, si, so, data_oe;
    wire [10:0] a;
    wire [7:0] bus, data_out;
    int bad_count = 0;
    int n_tests = 0;
    int seed = 68913;
    logic [7:0] ref_mem [int];
    logic [10:0] adrs [$];
    logic [10:0] adr;
    logic [7:0] q;
    bit ok;
    hcp_port i_dut (.mclk(mclk), .rst_n(rst_n), .port_type_select(ps),
        .bus_style_select(style), .bus_multiplex_select(mux), .cs_n(cs_n),
        .address_strobe_n(as_n), .data_strobe_n(ds_n), .serial_in(si), .addr(a),
        .data_in(bus), .data_out(data_out), .data_oe(data_oe), .serial_out(so));
    hcp_host_model i_host (.mclk(mclk), .ps(ps), .style(style), .mux(mux), .cs_n(cs_n),
        .as_n(as_n), .ds_n(ds_n), .si(si), .a(a), .bus(bus), .data_out(data_out),
        .data_oe(data_oe), .so(so));
    // system clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one access through the host model; reads compared with the byte model
    task automatic acc(input bit rd, input logic [10:0] ad, input logic [7:0] d);
        ok = 1;
        if (ps)
            i_host.par(rd, ad, d, q, ok);
        else
            i_host.ser(rd, ad, d, q);
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, so, 1'b0);
            wrap_up();
        end else if (rd)
            chk(q, ref_mem[ad]);
        else
            ref_mem[ad] = d;
    endtask
    // every mode writes the edge addresses and random ones, then reads back at random
    initial begin
        i_host.idle();
        repeat (20) @(negedge mclk);
        rst_n = 1;
        foreach (MODES[m]) begin
            @(negedge mclk);
            {ps, style, mux} = MODES[m];
            // let the new straps reach the host model's ports before it picks idle levels
            @(negedge mclk);
            i_host.idle();
            repeat (10) @(negedge mclk);
            for (int k = 0; k < 4; k++) begin
                adr = k == 0 ? 11'h000 : k == 1 ? 11'h7FF : 11'($random(seed));
                adrs.push_back(adr);
                acc(0, adr, 8'($random(seed)));
            end
            for (int k = 0; k < 4; k++) begin
                acc(1, adrs[{$random(seed)} % adrs.size()], 8'h00);
            end
            $display("mode %b finished", MODES[m]);
        end
        // a reset in mid-run puts the outputs back to idle at once
        rst_n = 0;
        #1;
        chk(data_out, 8'h00);
        chk({6'h00, data_oe, so}, 8'h01);
        wrap_up();
    end
endmodule // tb_top
